/* rtl/output_enable_sideband_gating.sv */
`timescale 1ns/1ps
`default_nettype none
module output_enable_sideband_gating
  import oe_gating_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PIN_OE-1:0] hundred_mhz_oe_n,
  input wire logic sideband_shift_clock,
  input wire logic sideband_serial_in,
  input wire logic shift_load_strobe_n,
  output logic sideband_serial_out,
  input wire logic power_good,
  input wire logic early_25m_power_good,
  input wire logic hundred_mhz_complement_clock,
  input wire logic [NUM_OUTPUTS-1:0] source_clocks,
  output logic [NUM_OUTPUTS-1:0] clock_outputs
);
  top_state_type st_r;
  top_state_type st_nxt;

  side_pins_type pins_raw;
  side_pins_type pins_lvl;
  side_pins_type pins_rise;
  side_pins_type pins_fall;
  logic [NUM_PIN_OE-1:0] oe_lvl;
  logic [NUM_OUTPUTS-1:0] src_lvl;
  logic [NUM_OUTPUTS-1:0] pin_en;
  logic [NUM_OUTPUTS-1:0] power_en;
  logic [NUM_OUTPUTS-1:0] sideband_en;
  logic [NUM_OUTPUTS-1:0] want_all;
  logic [NUM_OUTPUTS-1:0] gate_applied;
  logic [NUM_OUTPUTS-1:0] shift_expect;
  logic [NUM_PIN_OE-1:0] pin_block;
  logic [31:0] status_word;
  logic shift_step;
  logic apb_setup;
  logic apb_done;
  logic apb_wr;

  assign pins_raw.comp_clock = hundred_mhz_complement_clock;
  assign pins_raw.early_pg = early_25m_power_good;
  assign pins_raw.power_good = power_good;
  assign pins_raw.strobe_n = shift_load_strobe_n;
  assign pins_raw.serial_in = sideband_serial_in;
  assign pins_raw.shift_clock = sideband_shift_clock;

  // the shift clock is oversampled; it must stay well under pclk/4 to
  // be seen reliably, so full 25 MHz needs a faster pclk
  pin_sync #(
    .WIDTH($bits(side_pins_type))
  ) u_side_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pins_raw),
    .level(pins_lvl),
    .rise(pins_rise),
    .fall(pins_fall)
  );

  pin_sync #(
    .WIDTH(NUM_PIN_OE)
  ) u_oe_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(hundred_mhz_oe_n),
    .level(oe_lvl),
    .rise(),
    .fall()
  );

  pin_sync #(
    .WIDTH(NUM_OUTPUTS)
  ) u_src_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(source_clocks),
    .level(src_lvl),
    .rise(),
    .fall()
  );

  glitchless_gate #(
    .WIDTH(NUM_OUTPUTS)
  ) u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .src(src_lvl),
    .want(want_all),
    .clk_out(clock_outputs),
    .applied(gate_applied)
  );

  // enable paths
  always_comb begin
    pin_en = '1;
    pin_en[NUM_PIN_OE-1:0] = ~oe_lvl;
    power_en = {NUM_OUTPUTS{~st_r.power_stop}};
    power_en[BIT_Q25_TWO] = ~st_r.power_stop | pins_lvl.early_pg;
  end

  assign sideband_en = st_r.override | st_r.latched;
  // override sits only inside the sideband term
  assign want_all = pin_en & st_r.host_enable & sideband_en & power_en;
  assign pin_block = oe_lvl & ~src_lvl[NUM_PIN_OE-1:0];

  // first bit in ends in the top stage, platform time
  assign shift_expect = {st_r.shift[NUM_OUTPUTS-2:0], pins_lvl.serial_in};
  assign shift_step = pins_rise.shift_clock & pins_lvl.strobe_n;

  assign apb_setup = psel & ~penable;
  assign apb_done = psel & penable & st_r.pready;
  assign apb_wr = apb_done & pwrite & ~st_r.pslverr;

  always_comb begin
    status_word = '0;
    status_word[STAT_OE_PINS_LSB +: NUM_PIN_OE] = oe_lvl;
    status_word[STAT_POWER_STOP_BIT] = st_r.power_stop;
    status_word[STAT_POWER_GOOD_BIT] = pins_lvl.power_good;
    status_word[STAT_EARLY_PG_BIT] = pins_lvl.early_pg;
    status_word[STAT_STROBE_BIT] = pins_lvl.strobe_n;
  end

  always_comb begin
    st_nxt = st_r;
    // sideband shift and latch
    if (shift_step) begin
      st_nxt.shift = shift_expect;
    end
    if (pins_fall.strobe_n) begin
      st_nxt.latched = st_r.shift;
    end
    st_nxt.serial_out = st_nxt.shift[NUM_OUTPUTS-1];

    // power-good high runs; low stops on the complement fall after two complement-rise samples
    if (pins_lvl.power_good) begin
      st_nxt.pd_low_cnt = '0;
      st_nxt.power_stop = 1'b0;
    end else begin
      if (pins_rise.comp_clock && st_r.pd_low_cnt != PD_LOW_SAMPLES) begin
        st_nxt.pd_low_cnt = st_r.pd_low_cnt + 2'h1;
      end
      if (pins_fall.comp_clock && st_r.pd_low_cnt == PD_LOW_SAMPLES) begin
        st_nxt.power_stop = 1'b1;
      end
    end

    // apb: data and error set up in the setup phase, zero wait states
    st_nxt.pready = apb_setup;
    st_nxt.pslverr = 1'b0;
    if (apb_setup) begin
      st_nxt.prdata = '0;
      case (paddr)
        OFF_HOST_ENABLE: begin
          st_nxt.prdata[NUM_OUTPUTS-1:0] = st_r.host_enable;
        end
        OFF_OVERRIDE: begin
          st_nxt.prdata[NUM_OUTPUTS-1:0] = st_r.override;
        end
        OFF_LATCHED: begin
          st_nxt.prdata[NUM_OUTPUTS-1:0] = st_r.latched;
          st_nxt.pslverr = pwrite;
        end
        OFF_STATUS: begin
          st_nxt.prdata = status_word;
          st_nxt.pslverr = pwrite;
        end
        OFF_RUNNING: begin
          st_nxt.prdata[NUM_OUTPUTS-1:0] = gate_applied;
          st_nxt.pslverr = pwrite;
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr && paddr == OFF_HOST_ENABLE) begin
      st_nxt.host_enable = pwdata[NUM_OUTPUTS-1:0];
    end
    if (apb_wr && paddr == OFF_OVERRIDE) begin
      st_nxt.override = pwdata[NUM_OUTPUTS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.host_enable <= HOST_ENABLE_RESET;
      st_r.override <= OVERRIDE_RESET;
      st_r.shift <= SHIFT_RESET;
      st_r.latched <= LATCHED_RESET;
      st_r.pd_low_cnt <= '0;
      st_r.power_stop <= 1'b1;
      st_r.serial_out <= 1'b0;
      st_r.prdata <= '0;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign sideband_serial_out = st_r.serial_out;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [NUM_OUTPUTS-1:0] want_q;
  // a start is decided while the source was low, two cycles back
  logic [NUM_OUTPUTS-1:0] want_qq;
  logic [NUM_OUTPUTS-1:0] src_q;
  logic [NUM_OUTPUTS-1:0] out_q;
  logic [NUM_OUTPUTS-1:0] shift_q;
  logic [31:0] wdata_q;
  logic host_wr;
  logic shift_gap_ok;
  logic [3:0] shift_gap;

  assign host_wr = apb_wr & (paddr == OFF_HOST_ENABLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      want_q <= '0;
      want_qq <= '0;
      src_q <= '0;
      out_q <= '0;
      shift_q <= '0;
      wdata_q <= '0;
      shift_gap <= '0;
    end else begin
      want_q <= want_all;
      want_qq <= want_q;
      src_q <= src_lvl;
      out_q <= clock_outputs;
      shift_q <= st_r.shift;
      wdata_q <= pwdata;
      if (pins_rise.shift_clock) begin
        shift_gap <= '0;
      end else if (shift_gap != 4'hf) begin
        shift_gap <= shift_gap + 4'h1;
      end
    end
  end

  // no increment here: the saturated count would wrap to zero
  assign shift_gap_ok = shift_gap >= 4'(SHIFT_MIN_CYCLES - 1);

  sequence apb_setup_seq;
    psel && !penable;
  endsequence

  sequence apb_answer_seq;
    pready ##1 !pready;
  endsequence

  sequence pd_armed_seq;
    !pins_lvl.power_good && st_r.pd_low_cnt == PD_LOW_SAMPLES &&
      pins_fall.comp_clock;
  endsequence

  a_output_start_cause: assert property (
    ((clock_outputs & ~out_q & ~want_qq) == '0))
    else $error("output started without all enable paths");

  a_no_runt_phase: assert property (
    ((out_q & ~clock_outputs & src_q) == '0))
    else $error("output fell while its source was high");

  a_pin_gate: assert property (
    (pin_block != '0) |=>
      ((gate_applied[NUM_PIN_OE-1:0] & $past(pin_block)) == '0))
    else $error("disabled pin left output enabled");

  a_host_write: assert property (
    host_wr |=> st_r.host_enable == wdata_q[NUM_OUTPUTS-1:0])
    else $error("host enable write not taken");

  a_shift_step: assert property (
    shift_step |=> st_r.shift == $past(shift_expect))
    else $error("shift register did not shift");

  a_latch_copy: assert property (
    pins_fall.strobe_n |=> st_r.latched == shift_q)
    else $error("strobe fall did not latch shift register");

  a_sideband_or: assert property (
    ((want_all & ~(st_r.override | st_r.latched)) == '0))
    else $error("sideband disable ignored");

  a_host_wins: assert property (
    ((want_all & ~st_r.host_enable) == '0))
    else $error("override defeated host disable");

  a_latched_read: assert property (
    (apb_setup && paddr == OFF_LATCHED) |=>
      prdata[NUM_OUTPUTS-1:0] == $past(st_r.latched))
    else $error("latched register read mismatch");

  a_shift_hold: assert property (
    !pins_lvl.strobe_n |=> st_r.shift == shift_q)
    else $error("shift register moved with strobe low");

  a_power_stop: assert property (
    pd_armed_seq |=> st_r.power_stop)
    else $error("power down did not stop outputs");

  a_power_gate: assert property (
    st_r.power_stop |->
      ((want_all & ~(NUM_OUTPUTS'(1) << BIT_Q25_TWO)) == '0))
    else $error("output enabled during power down");

  a_serial_out: assert property (
    shift_step |=> sideband_serial_out == $past(st_r.shift[NUM_OUTPUTS-2]))
    else $error("serial out is not the last stage");

  a_shift_rate: assert property (
    pins_rise.shift_clock |-> shift_gap_ok)
    else $error("shift clock faster than allowed");

  a_apb_ready: assert property (
    apb_setup_seq |=> apb_answer_seq)
    else $error("apb answer not in one cycle");
endmodule
`default_nettype wire

/* rtl/oe_gating_pkg.sv */
package oe_gating_pkg;
  // output index map: 100 MHz 0..6, mux 7..15, 25 MHz 16..18, time 19
  localparam int NUM_OUTPUTS = 20;
  localparam int NUM_PIN_OE = 7;
  localparam int BIT_Q25_TWO = 18;
  localparam int BIT_PLATFORM_TIME = 19;

  localparam logic [11:0] OFF_HOST_ENABLE = 12'h000;
  localparam logic [11:0] OFF_OVERRIDE = 12'h004;
  localparam logic [11:0] OFF_LATCHED = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_RUNNING = 12'h010;

  localparam logic [19:0] HOST_ENABLE_RESET = 20'hfffff;
  localparam logic [19:0] OVERRIDE_RESET = 20'h00000;
  localparam logic [19:0] LATCHED_RESET = 20'hfffff;
  localparam logic [19:0] SHIFT_RESET = 20'h00000;

  localparam int STAT_OE_PINS_LSB = 0;
  localparam int STAT_POWER_STOP_BIT = 8;
  localparam int STAT_POWER_GOOD_BIT = 9;
  localparam int STAT_EARLY_PG_BIT = 10;
  localparam int STAT_STROBE_BIT = 11;

  localparam logic [1:0] PD_LOW_SAMPLES = 2'h2;

  localparam int PCLK_HZ = 50_000_000;
  localparam int SHIFT_CLK_MAX_HZ = 25_000_000;
  // least period of the shift clock, rounded up to pclk cycles
  localparam int SHIFT_MIN_CYCLES =
    (PCLK_HZ + SHIFT_CLK_MAX_HZ - 1) / SHIFT_CLK_MAX_HZ;

  typedef struct packed {
    logic comp_clock;
    logic early_pg;
    logic power_good;
    logic strobe_n;
    logic serial_in;
    logic shift_clock;
  } side_pins_type;

  typedef struct packed {
    logic [19:0] host_enable;
    logic [19:0] override;
    logic [19:0] shift;
    logic [19:0] latched;
    logic [1:0] pd_low_cnt;
    logic power_stop;
    logic serial_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } top_state_type;
endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;
  logic [WIDTH-1:0] change;

  // a change counts only once stages two and three agree
  assign change = ~(st_r.s2 ^ st_r.s3) & (st_r.s3 ^ st_r.stable);
  assign level = st_r.stable;
  assign rise = change & st_r.s3;
  assign fall = change & ~st_r.s3;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.stable = st_r.stable ^ change;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

/* rtl/glitchless_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module glitchless_gate #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] src,
  input wire logic [WIDTH-1:0] want,
  output logic [WIDTH-1:0] clk_out,
  output logic [WIDTH-1:0] applied
);
  typedef struct packed {
    logic [WIDTH-1:0] applied;
    logic [WIDTH-1:0] out;
  } gate_state_type;

  gate_state_type st_r;
  gate_state_type st_nxt;

  assign clk_out = st_r.out;
  assign applied = st_r.applied;

  // enable only moves while the source is low, so no phase is cut short
  always_comb begin
    st_nxt.applied = (st_r.applied & src) | (want & ~src);
    st_nxt.out = src & st_nxt.applied;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

/* bench/sideband_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sideband_ctrl_model (
  output logic shift_clock,
  output logic serial_in,
  output logic strobe_n,
  input wire logic chain_in
);
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    strobe_n = 1'b0;
  end
  // one frame, msb first; clock parked low outside frames except in noise; every pin
  // change sits at least 5 ns off a rising pclk edge, never on a sampling edge
  // got holds what a downstream device would take from chain_in
  task automatic send(input logic [19:0] word, input int nbits,
    output logic [19:0] got);
    got = 20'h00000;
    #5 strobe_n = 1'b1;
    #100;
    for (int i = 19; i > 19 - nbits; i--) begin
      serial_in = word[i];
      #80 got[i] = chain_in;
      shift_clock = 1'b1;
      #80 shift_clock = 1'b0;
    end
    // data pin has a pull-down, so a released line reads low
    serial_in = 1'b0;
    #100 strobe_n = 1'b0;
    #200;
  endtask
  // clock and data activity with the strobe low
  task automatic noise();
    #5;
    repeat (5) begin
      serial_in = ~serial_in;
      #80 shift_clock = 1'b1;
      #80 shift_clock = 1'b0;
    end
    serial_in = 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/output_enable_sideband_gating_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module output_enable_sideband_gating_tb_top;
  import oe_gating_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] oe_n = 7'h00;
  logic power_good = 1'b1;
  logic early_pg = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [19:0] clock_outputs;
  logic sck;
  logic sdi;
  logic sld_n;
  logic sdo;
  logic [31:0] rdata;
  logic rerr;
  logic [19:0] h;
  logic [19:0] o;
  logic [19:0] l;
  logic [19:0] pl;
  logic [19:0] got;
  int seed;
  int n_mismatch = 0;
  int n_compared = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) cnt <= cnt + 8'h01;
  sideband_ctrl_model sb (.shift_clock(sck), .serial_in(sdi),
    .strobe_n(sld_n), .chain_in(sdo));
  output_enable_sideband_gating dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hundred_mhz_oe_n(oe_n), .sideband_shift_clock(sck),
    .sideband_serial_in(sdi), .shift_load_strobe_n(sld_n),
    .sideband_serial_out(sdo), .power_good(power_good),
    .early_25m_power_good(early_pg),
    .hundred_mhz_complement_clock(cnt[2]),
    .source_clocks({NUM_OUTPUTS{cnt[1]}}), .clock_outputs(clock_outputs));
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [19:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {12'h000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      close_out();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [19:0] exp_run(input logic [19:0] he, ov, la,
    input logic [6:0] n, input logic pg, ep);
    logic [19:0] e;
    e = he & (ov | la);
    e[6:0] = e[6:0] & ~n;
    if (!pg) e = e & (ep ? (20'h00001 << BIT_Q25_TWO) : 20'h00000);
    return e;
  endfunction
  // outputs must toggle where enabled and stay low elsewhere
  task automatic observe(input logic [19:0] want);
    logic [19:0] acc_or;
    logic [19:0] acc_and;
    acc_or = 20'h00000;
    acc_and = 20'hfffff;
    repeat (30) @(posedge pclk);
    apb(1'b0, OFF_RUNNING, 20'h00000);
    check(rdata, {12'h000, want});
    repeat (16) begin
      @(posedge pclk);
      acc_or = acc_or | clock_outputs;
      acc_and = acc_and & clock_outputs;
    end
    check({12'h000, acc_or}, {12'h000, want});
    check({12'h000, acc_and}, 32'h00000000);
  endtask
  initial begin
    #1ms;
    n_mismatch++;
    close_out();
  end
  initial begin
    seed = 31;
    pl = SHIFT_RESET;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_HOST_ENABLE, 20'h00000);
    check(rdata, {12'h000, HOST_ENABLE_RESET});
    apb(1'b0, OFF_OVERRIDE, 20'h00000);
    check(rdata, {12'h000, OVERRIDE_RESET});
    apb(1'b0, OFF_LATCHED, 20'h00000);
    check(rdata, {12'h000, LATCHED_RESET});
    apb(1'b1, OFF_LATCHED, 20'h12345);
    check({31'h00000000, rerr}, 32'h00000001);
    apb(1'b0, 12'h020, 20'h00000);
    check({31'h00000000, rerr}, 32'h00000001);
    check(rdata, 32'h00000000);
    apb(1'b0, OFF_STATUS, 20'h00000);
    check(rdata, 32'h00000001 << STAT_POWER_GOOD_BIT);
    $display("test registers done");
    for (int t = 0; t < 10; t++) begin
      h = 20'($random(seed) | $random(seed));
      o = (t == 1) ? 20'hfffff : 20'($random(seed) & $random(seed));
      l = (t == 0) ? 20'h00000 : 20'($random(seed));
      oe_n <= (t == 2) ? 7'h7f : 7'($random(seed) & $random(seed));
      apb(1'b1, OFF_HOST_ENABLE, h);
      apb(1'b1, OFF_OVERRIDE, o);
      apb(1'b0, OFF_OVERRIDE, 20'h00000);
      check(rdata, {12'h000, o});
      sb.send(l, 20, got);
      @(posedge pclk);
      check({12'h000, got}, {12'h000, pl});
      pl = l;
      apb(1'b0, OFF_LATCHED, 20'h00000);
      check(rdata, {12'h000, l});
      check({31'h00000000, sdo}, {31'h00000000, l[19]});
      observe(exp_run(h, o, l, oe_n, 1'b1, 1'b0));
    end
    $display("test sideband random done");
    // activity with the strobe low must leave the old word in place,
    // so the next full frame pushes exactly that word out
    sb.noise();
    l = 20'ha5c3e;
    sb.send(l, 20, got);
    @(posedge pclk);
    check({12'h000, got}, {12'h000, pl});
    apb(1'b0, OFF_LATCHED, 20'h00000);
    check(rdata, {12'h000, l});
    check({31'h00000000, sdo}, {31'h00000000, l[19]});
    $display("test strobe low done");
    apb(1'b1, OFF_HOST_ENABLE, 20'hfffff);
    apb(1'b1, OFF_OVERRIDE, 20'hfffff);
    oe_n <= 7'h00;
    for (int p = 0; p < 2; p++) begin
      early_pg <= p[0];
      power_good <= 1'b0;
      observe(exp_run(20'hfffff, 20'hfffff, l, 7'h00, 1'b0, p[0]));
      power_good <= 1'b1;
      observe(20'hfffff);
    end
    $display("test power down done");
    close_out();
  end
endmodule
`default_nettype wire
